// File: pkg/vecm_pkg.sv
// Constants for the acceleration vector change detector
`default_nettype none
package vecm_pkg;
    localparam int AXIS_W = 14;
    localparam int THS_W = 13;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h5f;
    localparam logic [ADDR_W-1:0] INT_SOURCE_OFFSET = 8'h0c;
    localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
    localparam int LATCH_BIT = 6;
    localparam int INITM_BIT = 5;
    localparam int UPDM_BIT = 4;
    localparam int EN_BIT = 3;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    localparam int MAX_ODR_HZ = 400;
    typedef logic signed [AXIS_W-1:0] axis_t;
endpackage : vecm_pkg
`default_nettype wire

// File: hdl/accel_vector_change_detector.sv
// Acceleration vector-magnitude change detector with its configuration register
`default_nettype none
// Notes on behaviour
// [R1] The event flag sets when the distance from the reference exceeds the threshold past the debounce count.
// [R2] One reference per axis is held, captured internally or taken from the preset values.
// [R3] The held references cannot be read through any register.
// [R4] With latching off the flag follows the condition and clears once the debounce counter steps back to zero after it stops being true.
// [R5] With latching off both setting and clearing of the flag go through the debounce count.
// [R6] With latching on the flag holds until the host reads the interrupt source register.
// [R7] With init select clear, enabling captures the current three axis outputs as references.
// [R8] With init select set, enabling loads the references from the three preset values.
// [R9] With update mode clear, each trigger replaces the references with the current outputs.
// [R10] With update mode set, a trigger leaves the references unchanged.
// [R11] With init select and update mode both set, a preset write becomes the reference at once.
// [R12] The function runs only while the enable bit is set, which resets to zero, and setting it loads references.
// [R13] The host keeps the sample rate at or below 400 Hz for correct operation.
// [R14] Below threshold the debounce counter steps down by one, or clears when the clear mode bit is set.
// [R15] The debounce period is the count times one sample period, so a halved rate doubles it.
// [R16] The magnitude is compared with a 13-bit unsigned threshold in sample units.
// [R17] Comparison and counting advance once per new sample while enabled.
module accel_vector_change_detector (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [vecm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [vecm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [vecm_pkg::DATA_W-1:0] reg_rdata,
    // Acceleration samples
    input wire logic sample_valid,
    input wire vecm_pkg::axis_t accel_x,
    input wire vecm_pkg::axis_t accel_y,
    input wire vecm_pkg::axis_t accel_z,
    // Settings held elsewhere
    input wire logic [vecm_pkg::THS_W-1:0] threshold,
    input wire logic debounce_clear_mode,
    input wire logic [vecm_pkg::CNT_W-1:0] debounce_count,
    input wire vecm_pkg::axis_t preset_x,
    input wire vecm_pkg::axis_t preset_y,
    input wire vecm_pkg::axis_t preset_z,
    input wire logic preset_wr,
    // Event
    output logic vector_event
);
    import vecm_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    logic [DATA_W-1:0] cfg_r;
    logic [DATA_W-1:0] rdata_r;
    logic flag_r;
    logic flag_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    axis_t ref_r [3];
    axis_t ref_nxt [3];
    axis_t cur [3];
    axis_t pre [3];
    logic [2*AXIS_W+1:0] sq [3];

    assign cur[0] = accel_x;
    assign cur[1] = accel_y;
    assign cur[2] = accel_z;
    assign pre[0] = preset_x;
    assign pre[1] = preset_y;
    assign pre[2] = preset_z;

    wire cfg_wr = reg_wr && hit(reg_addr, CFG_OFFSET);
    wire src_rd = reg_rd && hit(reg_addr, INT_SOURCE_OFFSET);
    wire en = cfg_r[EN_BIT];
    wire latch_on = cfg_r[LATCH_BIT];
    wire initm = cfg_r[INITM_BIT];
    wire updm = cfg_r[UPDM_BIT];
    wire enable_go = cfg_wr && reg_wdata[EN_BIT] && !en; // R12
    wire live_preset = en && initm && updm && preset_wr;
    wire step = en && sample_valid && !enable_go; // R17

    // Per-axis squared distance from reference
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            wire signed [AXIS_W:0] diff = (AXIS_W+1)'(cur[g]) - (AXIS_W+1)'(ref_r[g]);
            wire signed [2*AXIS_W+1:0] prod = diff * diff;
            assign sq[g] = prod;
        end
    endgenerate

    // Squared compare avoids the root
    wire [2*AXIS_W+3:0] dist2 = (2*AXIS_W+4)'(sq[0]) + (2*AXIS_W+4)'(sq[1])
                              + (2*AXIS_W+4)'(sq[2]);
    wire [2*THS_W-1:0] ths2 = threshold * threshold;
    wire above = dist2 > (2*AXIS_W+4)'(ths2); // R1 R16

    wire below_top = (cnt_r < debounce_count) || (debounce_count == '0);
    wire [CNT_W-1:0] cnt_up = (cnt_r < debounce_count) ? cnt_r + 8'h01 : cnt_r;
    wire [CNT_W-1:0] cnt_down = debounce_clear_mode ? 8'h00 : // R14
                                (cnt_r == 8'h00 ? 8'h00 : cnt_r - 8'h01);
    wire trig = step && above && below_top && (cnt_up == debounce_count); // R1 R15
    wire fall = step && !above && (cnt_down == 8'h00); // R5

    always_comb begin
        cnt_nxt = cnt_r;
        if (!en || enable_go) begin
            cnt_nxt = '0;
        end else if (step) begin
            cnt_nxt = above ? cnt_up : cnt_down;
        end
    end

    always_comb begin
        flag_nxt = flag_r;
        if (!en) begin
            flag_nxt = 1'b0; // R12
        end else if (trig) begin
            flag_nxt = 1'b1; // R1
        end else if (latch_on) begin
            if (src_rd) begin
                flag_nxt = 1'b0; // R6
            end
        end else if (fall) begin
            flag_nxt = 1'b0; // R4 R5
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ref_nxt[i] = ref_r[i];
            if (enable_go) begin
                ref_nxt[i] = reg_wdata[INITM_BIT] ? pre[i] : cur[i]; // R7 R8
            end else if (live_preset) begin
                ref_nxt[i] = pre[i]; // R11
            end else if (trig && !updm) begin
                ref_nxt[i] = cur[i]; // R9 R10
            end
        end
    end

    // References only reach internal logic
    wire [DATA_W-1:0] rd_mux = hit(reg_addr, CFG_OFFSET) ? cfg_r : UNMAPPED_READ; // R3

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r <= CFG_RESET;
            rdata_r <= UNMAPPED_READ;
            flag_r <= 1'b0;
            cnt_r <= '0;
            for (int i = 0; i < 3; i++) begin
                ref_r[i] <= '0;
            end
        end else begin
            if (cfg_wr) begin
                cfg_r <= reg_wdata;
            end
            if (reg_rd) begin
                rdata_r <= rd_mux;
            end
            flag_r <= flag_nxt;
            cnt_r <= cnt_nxt;
            for (int i = 0; i < 3; i++) begin
                ref_r[i] <= ref_nxt[i]; // R2
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign vector_event = flag_r;

    property p_set;
        @(posedge sys_clk) disable iff (sys_rst) trig && !cfg_wr |=> flag_r;
    endproperty
    a_set: assert property (p_set) else $error("flag missed a trigger"); // R1
    property p_hidden;
        @(posedge sys_clk) disable iff (sys_rst)
            reg_rd && !hit(reg_addr, CFG_OFFSET) |=> reg_rdata == 8'h00;
    endproperty
    a_hidden: assert property (p_hidden) else $error("unmapped read not zero"); // R3
    property p_hold;
        @(posedge sys_clk) disable iff (sys_rst)
            en && latch_on && flag_r && !src_rd && !cfg_wr |=> flag_r;
    endproperty
    a_hold: assert property (p_hold) else $error("latched flag dropped"); // R6
    property p_clear_read;
        @(posedge sys_clk) disable iff (sys_rst)
            en && latch_on && src_rd && !trig |=> !flag_r;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("read did not clear"); // R6
    property p_nonlatch_clear;
        @(posedge sys_clk) disable iff (sys_rst)
            en && !latch_on && fall && !cfg_wr |=> !flag_r;
    endproperty
    a_nonlatch_clear: assert property (p_nonlatch_clear) else $error("flag not cleared"); // R4
    property p_dbclr;
        @(posedge sys_clk) disable iff (sys_rst)
            step && !above && debounce_clear_mode && !cfg_wr |=> cnt_r == 8'h00;
    endproperty
    a_dbclr: assert property (p_dbclr) else $error("counter not cleared"); // R14
    property p_dbdec;
        @(posedge sys_clk) disable iff (sys_rst)
            step && !above && !debounce_clear_mode && cnt_r != 8'h00 && !cfg_wr
            |=> cnt_r == $past(cnt_r) - 8'h01;
    endproperty
    a_dbdec: assert property (p_dbdec) else $error("counter not decremented"); // R14
    property p_idle;
        @(posedge sys_clk) disable iff (sys_rst)
            en && !sample_valid && !cfg_wr && !src_rd |=> $stable(cnt_r) && $stable(flag_r);
    endproperty
    a_idle: assert property (p_idle) else $error("changed without sample"); // R17
    property p_off;
        @(posedge sys_clk) disable iff (sys_rst) !en && !cfg_wr |=> !flag_r && cnt_r == 8'h00;
    endproperty
    a_off: assert property (p_off) else $error("active while disabled"); // R12
    property p_upd;
        @(posedge sys_clk) disable iff (sys_rst)
            trig && !updm && !cfg_wr && !preset_wr |=> ref_r[0] == $past(accel_x);
    endproperty
    a_upd: assert property (p_upd) else $error("reference not refreshed"); // R9
    property p_keep;
        @(posedge sys_clk) disable iff (sys_rst)
            trig && updm && !cfg_wr && !preset_wr |=> $stable(ref_r[1]);
    endproperty
    a_keep: assert property (p_keep) else $error("reference changed"); // R10
    property p_init;
        @(posedge sys_clk) disable iff (sys_rst)
            enable_go |=> ref_r[2] == ($past(reg_wdata[INITM_BIT]) ? $past(preset_z)
                                                                   : $past(accel_z));
    endproperty
    a_init: assert property (p_init) else $error("wrong reference at enable"); // R7 R8
    property p_live;
        @(posedge sys_clk) disable iff (sys_rst) live_preset && !cfg_wr |=> ref_r[0] == $past(preset_x);
    endproperty
    a_live: assert property (p_live) else $error("preset not live"); // R11
    c_trig: cover property (@(posedge sys_clk) disable iff (sys_rst) trig);
    c_latched_read: cover property (@(posedge sys_clk) disable iff (sys_rst)
        latch_on && flag_r && src_rd);
    c_fall: cover property (@(posedge sys_clk) disable iff (sys_rst) flag_r && fall);
endmodule : accel_vector_change_detector
`default_nettype wire

// File: dv/host_model.sv
// Host processor model: configuration port and externally held settings
`default_nettype none
module host_model #(
    parameter int ODR_HZ = 100
) (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Settings
    output logic [12:0] threshold,
    output logic debounce_clear_mode,
    output logic [7:0] debounce_count,
    output vecm_pkg::axis_t preset_x,
    output vecm_pkg::axis_t preset_y,
    output vecm_pkg::axis_t preset_z,
    output logic preset_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    import vecm_pkg::*;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd, threshold, debounce_clear_mode,
        debounce_count, preset_x, preset_y, preset_z, preset_wr} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : rd
    task automatic setup(input int t, input int n, input logic c);
        @(posedge sys_clk);
        threshold <= 13'(t);
        debounce_count <= 8'(n);
        debounce_clear_mode <= c;
    endtask : setup
    task automatic preset(input axis_t x, input axis_t y, input axis_t z);
        @(posedge sys_clk);
        {preset_x, preset_y, preset_z} <= {x, y, z};
        preset_wr <= 1'b1;
        @(posedge sys_clk);
        preset_wr <= 1'b0;
    endtask : preset
endmodule : host_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking testbench for the vector change detector
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import vecm_pkg::*;
    logic sys_clk = 0, sys_rst = 1, sample_valid = 0, reg_wr, reg_rd, preset_wr;
    logic debounce_clear_mode, vector_event;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, debounce_count, rd_val;
    logic [12:0] threshold;
    axis_t accel_x = 0, accel_y = 0, accel_z = 0, preset_x, preset_y, preset_z, bx, by, bz, fx;
    int error_cnt = 0, checked = 0, ths, dx, dy, dz;
    host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .threshold(threshold),
        .debounce_clear_mode(debounce_clear_mode), .debounce_count(debounce_count),
        .preset_x(preset_x), .preset_y(preset_y), .preset_z(preset_z), .preset_wr(preset_wr));
    accel_vector_change_detector dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .accel_x(accel_x),
        .accel_y(accel_y), .accel_z(accel_z), .threshold(threshold),
        .debounce_clear_mode(debounce_clear_mode), .debounce_count(debounce_count),
        .preset_x(preset_x), .preset_y(preset_y), .preset_z(preset_z),
        .preset_wr(preset_wr), .vector_event(vector_event));
    always #20 sys_clk = ~sys_clk;
    function automatic logic above(int x, int y, int z);
        return x * x + y * y + z * z > ths * ths;
    endfunction : above
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic fl(input logic e);
        chk("vector_event", {7'h0, e}, {7'h0, vector_event});
    endtask : fl
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rd_val);
        chk("reg_rdata", e, rd_val);
    endtask : rdchk
    task automatic smp(input axis_t x, input axis_t y, input axis_t z, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            sample_valid <= 1'b1;
            {accel_x, accel_y, accel_z} <= {x, y, z};
            @(posedge sys_clk);
            sample_valid <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask : smp
    // Sample at the reference or one step past threshold on x
    task automatic go(input logic f, input int n);
        smp(f ? fx : bx, by, bz, n);
    endtask : go
    task automatic results;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    // Whole run is under a thousand cycles
    initial begin
        #400000;
        error_cnt++;
        results();
    end
    initial begin
        void'($urandom(32'hc8a1));
        ths = 100 + $urandom % 1000;
        {bx, by, bz} = {14'($urandom % 512), 14'($urandom % 512), 14'($urandom % 512)};
        fx = axis_t'(bx + ths + 1);
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdchk(CFG_OFFSET, CFG_RESET);
        rdchk(8'h63, UNMAPPED_READ);
        rd_val = 8'($urandom) & 8'hf7;
        host.wr(CFG_OFFSET, rd_val);
        rdchk(CFG_OFFSET, rd_val);
        host.setup(ths, 1, 1'($urandom));
        go(1, 2);
        fl(0);
        go(0, 1);
        host.wr(CFG_OFFSET, 8'h18);
        for (int i = 0; i < 16; i++) begin
            {dx, dy, dz} = {32'(ths), 32'(0), 32'(0)};
            if (i == 1) {dx, dy, dz} = {32'(0), -32'(ths + 1), 32'(0)};
            if (i > 1) {dx, dy, dz} = {32'($urandom % 1300) - 650, 32'($urandom % 1300) - 650,
                32'($urandom % 1300) - 650};
            smp(axis_t'(bx + dx), axis_t'(by + dy), axis_t'(bz + dz), 1);
            fl(above(dx, dy, dz));
        end
        go(0, 1);
        host.setup(ths, 3, 0);
        go(1, 2);
        fl(0);
        go(1, 2);
        fl(1);
        go(0, 2);
        fl(1);
        go(0, 1);
        fl(0);
        host.setup(ths, 3, 1);
        go(1, 3);
        fl(1);
        go(0, 1);
        fl(0);
        go(1, 3);
        host.wr(CFG_OFFSET, 8'h00);
        repeat (2) @(posedge sys_clk);
        fl(0);
        host.setup(ths, 2, 0);
        go(0, 1);
        host.wr(CFG_OFFSET, 8'h48);
        go(1, 2);
        go(1, 3);
        fl(1);
        rdchk(INT_SOURCE_OFFSET, 8'h00);
        fl(0);
        go(1, 2);
        fl(0);
        go(0, 2);
        fl(1);
        host.wr(CFG_OFFSET, 8'h00);
        host.setup(ths, 1, 0);
        host.preset(bx, by, bz);
        go(1, 1);
        host.wr(CFG_OFFSET, 8'h38);
        go(0, 1);
        fl(0);
        host.preset(fx, by, bz);
        go(1, 1);
        fl(0);
        go(0, 1);
        fl(1);
        // Zero count triggers on the first sample above threshold
        host.setup(ths, 0, 0);
        go(1, 1);
        fl(0);
        go(0, 1);
        fl(1);
        results();
    end
endmodule : testbench
`default_nettype wire
